/* rtl/remote_ir_carrier_control.sv */
// Remote infrared carrier control: register bank, carrier out, band check
`timescale 1ns/100ps
`default_nettype none
module remote_ir_carrier_control (
   // Clock and reset
   input  wire logic                              clk_sys,
   input  wire logic                              rstn,
   // AXI4-Lite write address
   input  wire logic                              s_axi_awvalid,
   output logic                                   s_axi_awready,
   input  wire logic [remote_ir_pkg::ADDR_W-1:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic                              s_axi_wvalid,
   output logic                                   s_axi_wready,
   input  wire logic [remote_ir_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                        s_axi_wstrb,
   // AXI4-Lite write response
   output logic                                   s_axi_bvalid,
   input  wire logic                              s_axi_bready,
   output logic      [1:0]                        s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic                              s_axi_arvalid,
   output logic                                   s_axi_arready,
   input  wire logic [remote_ir_pkg::ADDR_W-1:0]  s_axi_araddr,
   // AXI4-Lite read data
   output logic                                   s_axi_rvalid,
   input  wire logic                              s_axi_rready,
   output logic      [remote_ir_pkg::DATA_W-1:0]  s_axi_rdata,
   output logic      [1:0]                        s_axi_rresp,
   // Infrared line side
   input  wire logic                              tx_enable,
   output logic                                   tx_ir,
   input  wire logic                              rx_ir,
   output logic                                   rx_carrier_ok
);
   import remote_ir_pkg::*;

   typedef struct packed {
      logic                        awready;
      logic                        wready;
      logic                        arready;
      logic                        aw_have;
      logic [3:0]                  aw_idx;
      logic                        aw_mapped;
      logic                        w_have;
      logic [7:0]                  wdata;
      logic                        wlane;
      logic                        bvalid;
      logic [1:0]                  bresp;
      logic                        rvalid;
      logic [7:0]                  rdata;
      logic [1:0]                  rresp;
      logic [REG_COUNT-1:0][7:0]   regs;
      logic [17:0]                 acc;
      logic [11:0]                 pw_cnt;
      logic                        tx;
      logic                        rx_prev;
      logic [15:0]                 per_cnt;
      logic                        rx_ok;
   } state_t;

   state_t q;
   state_t d;

   logic [13:0] f_min;
   logic [13:0] f_max;
   logic        band_valid;
   logic [8:0]  tx_khz;
   logic        tx_code_ok;
   logic [11:0] pw_count;
   logic [3:0]  ar_idx;
   logic [7:0]  rd_val;
   logic [29:0] lo_prod;
   logic [29:0] hi_prod;

   // Decoded fields
   logic [2:0] rx_band_width_code;
   logic [4:0] rx_carrier_select;
   logic [2:0] tx_pulse_width_code;
   logic [4:0] tx_carrier_select;
   logic       rx_carrier_group;
   logic       tx_carrier_group;
   logic       keyed_carrier_infrared;

   assign rx_band_width_code  = q.regs[IDX_RX_CONTROL][CODE_HI:CODE_LO];
   assign rx_carrier_select   = q.regs[IDX_RX_CONTROL][SEL_HI:SEL_LO];
   assign tx_pulse_width_code = q.regs[IDX_TX_CONTROL][CODE_HI:CODE_LO];
   assign tx_carrier_select   = q.regs[IDX_TX_CONTROL][SEL_HI:SEL_LO];
   assign rx_carrier_group    = q.regs[IDX_IR_CONFIG][CFG_RX_GROUP];
   assign tx_carrier_group    = q.regs[IDX_IR_CONFIG][CFG_TX_GROUP];
   assign keyed_carrier_infrared = q.regs[IDX_MODE_STATUS][MODE_KEYED];

   rx_band_table u_band (
      .rx_carrier_group       (rx_carrier_group),
      .keyed_carrier_infrared (keyed_carrier_infrared),
      .rx_band_width_code     (rx_band_width_code),
      .rx_carrier_select      (rx_carrier_select),
      .f_min                  (f_min),
      .f_max                  (f_max),
      .band_valid             (band_valid)
   );

   // Transmit carrier frequency in kHz; reserved codes give no carrier
   always_comb begin
      tx_khz     = '0;
      tx_code_ok = 1'b0;
      if (tx_carrier_group) begin // R13
         tx_code_ok = 1'b1;
         case (tx_carrier_select) // R11
            HIGH_SEL0: tx_khz = TX_HIGH_F0;
            HIGH_SEL1: tx_khz = TX_HIGH_F1;
            HIGH_SEL2: tx_khz = TX_HIGH_F2;
            default:   tx_code_ok = 1'b0;
         endcase
      end else if (tx_carrier_select >= TX_LOW_FIRST &&
                   tx_carrier_select <= TX_LOW_LAST) begin
         tx_code_ok = 1'b1; // R11
         tx_khz     = 9'(tx_carrier_select) + TX_LOW_OFFSET;
      end
   end

   // Pulse width in clock cycles
   always_comb begin
      pw_count = '0;
      case (tx_pulse_width_code) // R10 R14
         3'h2:    pw_count = tx_carrier_group ? PW_HIGH2 : PW_LOW2;
         3'h3:    pw_count = tx_carrier_group ? PW_HIGH3 : PW_LOW3;
         3'h4:    pw_count = tx_carrier_group ? PW_HIGH4 : PW_LOW4;
         3'h5:    pw_count = tx_carrier_group ? PW_HIGH5 : PW_LOW5;
         default: pw_count = '0;
      endcase
   end

   // Read mux; status bits overlay the mode register
   assign ar_idx = s_axi_araddr[ADDR_W-1:2];
   always_comb begin
      rd_val = '0;
      if (ar_idx < 4'(REG_COUNT)) begin
         rd_val = q.regs[ar_idx]; // R01
      end
      if (ar_idx == IDX_MODE_STATUS) begin
         rd_val[STAT_RX_OK] = q.rx_ok;
         rd_val[STAT_TX]    = q.tx;
      end
   end

   // Frequency compare without division: f = RX_SCALE / period
   assign lo_prod = 30'(q.per_cnt) * 30'(f_min);
   assign hi_prod = 30'(q.per_cnt) * 30'(f_max);

   always_comb begin
      d = q;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_have   = 1'b1;
         d.aw_idx    = s_axi_awaddr[ADDR_W-1:2];
         d.aw_mapped = (s_axi_awaddr[ADDR_W-1:2] < 4'(REG_COUNT));
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_have = 1'b1;
         d.wdata  = s_axi_wdata[7:0];
         d.wlane  = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.bvalid) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = q.aw_mapped ? RESP_OKAY : RESP_SLVERR;
         if (q.aw_mapped && q.wlane) begin
            d.regs[q.aw_idx] = q.wdata & REG_WMASK[q.aw_idx*8 +: 8]; // R01
         end
      end
      d.awready = !d.aw_have && !d.bvalid;
      d.wready  = !d.w_have && !d.bvalid;

      // Read channel: one outstanding read
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata  = rd_val;
         d.rresp  = (ar_idx < 4'(REG_COUNT)) ? RESP_OKAY : RESP_SLVERR;
      end
      d.arready = !d.rvalid;

      // Carrier: phase accumulator keeps the average rate exact
      if (tx_enable && tx_code_ok && pw_count != '0) begin
         if (q.acc + 18'(tx_khz) >= ACC_WRAP) begin
            d.acc    = q.acc + 18'(tx_khz) - ACC_WRAP; // R14
            d.pw_cnt = pw_count;
            d.tx     = 1'b1;
         end else begin
            d.acc = q.acc + 18'(tx_khz);
            if (q.pw_cnt > 12'h001) begin
               d.pw_cnt = q.pw_cnt - 12'h001;
            end else begin
               d.pw_cnt = '0;
               d.tx     = 1'b0;
            end
         end
      end else begin
         // Disabled or reserved code: line held idle
         d.acc    = '0;
         d.pw_cnt = '0;
         d.tx     = 1'b0;
      end

      // Receive: measure period between rising edges
      d.rx_prev = rx_ir;
      if (rx_ir && !q.rx_prev) begin
         d.per_cnt = 16'h0001;
         d.rx_ok   = band_valid && (q.per_cnt != 16'hffff) &&
                     (lo_prod <= RX_SCALE) && (hi_prod >= RX_SCALE); // R03
      end else if (q.per_cnt != 16'hffff) begin
         d.per_cnt = q.per_cnt + 16'h0001;
      end else begin
         // Carrier lost: slower than any band
         d.rx_ok = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         q         <= '0;
         q.awready <= 1'b1;
         q.wready  <= 1'b1;
         q.arready <= 1'b1;
         q.regs    <= REG_RESET; // R02 R09
         q.per_cnt <= 16'hffff;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = q.awready;
   assign s_axi_wready  = q.wready;
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = {24'h000000, q.rdata};
   assign s_axi_rresp   = q.rresp;
   assign tx_ir         = q.tx;
   assign rx_carrier_ok = q.rx_ok;
endmodule
`default_nettype wire

/* rtl/remote_ir_pkg.sv */
// Constants for the remote infrared carrier control block
// What this block does
// R01 - Nine byte registers at indexes zero to eight
// R02 - Receiver control resets to range 001, select 01001
// R03 - Range field accepts only in-band incoming carriers
// R04 - Select field picks nominal receiver band centre
// R05 - Low receive table gives fixed kHz limits
// R06 - High receive band limits for range 001
// R07 - Keyed reception ranges widen band progressively
// R08 - Software programs only listed codes
// R09 - Transmitter control resets to width 011, select 01001
// R10 - Pulse width code sets emitted pulse width
// R11 - Transmit select field chooses carrier frequency
// R12 - Receive group bit picks low or high tables
// R13 - Transmit group bit picks low or high carrier
// R14 - Periods, widths, limits counted in clock cycles; band limits are held in 0.1 kHz units instead
`default_nettype none
package remote_ir_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W    = 6;
   localparam int unsigned DATA_W    = 32;
   localparam int unsigned REG_COUNT = 9;

   // Register indexes; byte address is four times the index
   localparam logic [3:0] IDX_RX_CONTROL   = 4'h0;
   localparam logic [3:0] IDX_TX_CONTROL   = 4'h1;
   localparam logic [3:0] IDX_IR_CONFIG    = 4'h2;
   localparam logic [3:0] IDX_BANK_SELECT  = 4'h3;
   localparam logic [3:0] IDX_FE_SELECT1   = 4'h4;
   localparam logic [3:0] IDX_FE_SELECT2   = 4'h5;
   localparam logic [3:0] IDX_FE_SELECT3   = 4'h6;
   localparam logic [3:0] IDX_FE_CONTROL   = 4'h7;
   localparam logic [3:0] IDX_MODE_STATUS  = 4'h8;

   // Reset values, index 8 down to 0
   localparam logic [REG_COUNT*8-1:0] REG_RESET =
      {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf4, 8'h00, 8'h69, 8'h29};
   // Writable bits; status bits of the mode register are read-only
   localparam logic [REG_COUNT*8-1:0] REG_WMASK =
      {8'h01, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};

   // Field positions
   localparam int unsigned CODE_HI      = 7;
   localparam int unsigned CODE_LO      = 5;
   localparam int unsigned SEL_HI       = 4;
   localparam int unsigned SEL_LO       = 0;
   localparam int unsigned CFG_RX_GROUP = 5;
   localparam int unsigned CFG_TX_GROUP = 3;
   localparam int unsigned MODE_KEYED   = 0;
   localparam int unsigned STAT_TX      = 6;
   localparam int unsigned STAT_RX_OK   = 7;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
   localparam logic [17:0] ACC_WRAP      = 18'(CLK_KHZ);
   localparam logic [29:0] RX_SCALE      = 30'(CLK_KHZ * 10);

   // Transmit carriers in kHz
   localparam logic [8:0] TX_LOW_OFFSET = 9'd27;
   localparam logic [8:0] TX_HIGH_F0    = 9'd400;
   localparam logic [8:0] TX_HIGH_F1    = 9'd450;
   localparam logic [8:0] TX_HIGH_F2    = 9'd480;
   localparam logic [4:0] TX_LOW_FIRST  = 5'h03;
   localparam logic [4:0] TX_LOW_LAST   = 5'h1d;
   localparam logic [4:0] HIGH_SEL0     = 5'h03;
   localparam logic [4:0] HIGH_SEL1     = 5'h08;
   localparam logic [4:0] HIGH_SEL2     = 5'h0b;

   // Pulse widths in ns, low and high group
   localparam int unsigned PW_LOW2_NS  = 6000;
   localparam int unsigned PW_LOW3_NS  = 7000;
   localparam int unsigned PW_LOW4_NS  = 9000;
   localparam int unsigned PW_LOW5_NS  = 10600;
   localparam int unsigned PW_HIGH2_NS = 700;
   localparam int unsigned PW_HIGH3_NS = 800;
   localparam int unsigned PW_HIGH4_NS = 900;
   localparam int unsigned PW_HIGH5_NS = 1000;
   localparam logic [11:0] PW_LOW2  = 12'(PW_LOW2_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_LOW3  = 12'(PW_LOW3_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_LOW4  = 12'(PW_LOW4_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_LOW5  = 12'(PW_LOW5_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_HIGH2 = 12'(PW_HIGH2_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_HIGH3 = 12'(PW_HIGH3_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_HIGH4 = 12'(PW_HIGH4_NS / CLK_PERIOD_NS);
   localparam logic [11:0] PW_HIGH5 = 12'(PW_HIGH5_NS / CLK_PERIOD_NS);

endpackage
`default_nettype wire

/* rtl/rx_band_table.sv */
// Receive acceptance band lookup, limits in units of 0.1 kHz
`timescale 1ns/100ps
`default_nettype none
module rx_band_table (
   // Selection
   input  wire logic        rx_carrier_group,
   input  wire logic        keyed_carrier_infrared,
   input  wire logic [2:0]  rx_band_width_code,
   input  wire logic [4:0]  rx_carrier_select,
   // Band limits
   output logic      [13:0] f_min,
   output logic      [13:0] f_max,
   output logic             band_valid
);
   logic [83:0] row;
   logic        row_ok;

   // Low table: ranges 001, 010, 011 as min/max pairs
   always_comb begin
      row_ok = 1'b1;
      case (rx_carrier_select) // R04 R05
         5'h02: row = {14'd261,14'd296,14'd247,14'd317,14'd234,14'd342};
         5'h03: row = {14'd282,14'd320,14'd267,14'd343,14'd253,14'd369};
         5'h04: row = {14'd294,14'd333,14'd278,14'd357,14'd263,14'd384};
         5'h05: row = {14'd300,14'd340,14'd284,14'd365,14'd269,14'd393};
         5'h06: row = {14'd314,14'd356,14'd296,14'd381,14'd281,14'd410};
         5'h07: row = {14'd321,14'd364,14'd303,14'd390,14'd287,14'd420};
         5'h08: row = {14'd328,14'd372,14'd310,14'd398,14'd294,14'd429};
         5'h09: row = {14'd336,14'd381,14'd317,14'd408,14'd301,14'd440};
         5'h0b: row = {14'd344,14'd390,14'd325,14'd418,14'd308,14'd450};
         5'h0c: row = {14'd362,14'd410,14'd342,14'd440,14'd324,14'd473};
         5'h0d: row = {14'd372,14'd421,14'd351,14'd451,14'd332,14'd486};
         5'h0f: row = {14'd382,14'd432,14'd360,14'd463,14'd341,14'd499};
         5'h10: row = {14'd403,14'd457,14'd381,14'd490,14'd361,14'd527};
         5'h12: row = {14'd415,14'd471,14'd392,14'd504,14'd372,14'd543};
         5'h13: row = {14'd428,14'd485,14'd404,14'd519,14'd383,14'd560};
         5'h15: row = {14'd441,14'd500,14'd417,14'd536,14'd395,14'd577};
         5'h17: row = {14'd455,14'd516,14'd430,14'd553,14'd407,14'd596};
         5'h1a: row = {14'd487,14'd552,14'd460,14'd591,14'd436,14'd637};
         5'h1b: row = {14'd504,14'd571,14'd476,14'd612,14'd451,14'd659};
         5'h1d: row = {14'd543,14'd615,14'd513,14'd659,14'd486,14'd710};
         default: begin
            row    = '0;
            row_ok = 1'b0;
         end
      endcase
   end

   always_comb begin
      f_min      = '0;
      f_max      = '0;
      band_valid = 1'b0;
      if (keyed_carrier_infrared) begin
         band_valid = 1'b1;
         case (rx_band_width_code) // R07
            3'h1: {f_min, f_max} = {14'd4800, 14'd5333};
            3'h2: {f_min, f_max} = {14'd4571, 14'd5647};
            3'h3: {f_min, f_max} = {14'd4364, 14'd6000};
            3'h4: {f_min, f_max} = {14'd4174, 14'd6400};
            3'h5: {f_min, f_max} = {14'd4000, 14'd6856};
            3'h6: {f_min, f_max} = {14'd3840, 14'd7385};
            default: band_valid = 1'b0;
         endcase
      end else if (rx_carrier_group) begin // R12
         band_valid = (rx_band_width_code == 3'h1);
         case (rx_carrier_select) // R06
            5'h03: {f_min, f_max} = {14'd3556, 14'd4571};
            5'h08: {f_min, f_max} = {14'd3801, 14'd4898};
            5'h0b: {f_min, f_max} = {14'd4103, 14'd5274};
            default: band_valid = 1'b0;
         endcase
      end else begin
         band_valid = row_ok;
         case (rx_band_width_code) // R03 R05
            3'h1: {f_min, f_max} = row[83:56];
            3'h2: {f_min, f_max} = row[55:28];
            3'h3: {f_min, f_max} = row[27:0];
            default: band_valid = 1'b0;
         endcase
      end
   end
endmodule
`default_nettype wire

/* tb/ir_front_end.sv */
// Front-end model: raw receive carrier source and transmit pulse meter
`timescale 1ns/100ps
`default_nettype none
module ir_front_end (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Carrier source, zero stops it
   input  wire logic [15:0] rx_period,
   output logic             rx_ir,
   // Transmit meter
   input  wire logic        tx_ir,
   output logic      [15:0] tx_period_seen,
   output logic      [15:0] tx_high_seen
);
   logic [15:0] cnt_q;
   logic [15:0] run_q;
   logic [15:0] hi_q;
   logic        tx_q;
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 16'h0;
         rx_ir <= 1'b0;
         run_q <= 16'h0;
         hi_q <= 16'h0;
         tx_q <= 1'b0;
         tx_period_seen <= 16'h0;
         tx_high_seen <= 16'h0;
      end else begin
         // Idle line rests low: no carrier means no energy
         cnt_q <= (rx_period == 16'h0 || cnt_q + 16'h1 >= rx_period) ?
                  16'h0 : cnt_q + 16'h1;
         rx_ir <= rx_period != 16'h0 && cnt_q < (rx_period >> 1);
         tx_q <= tx_ir;
         run_q <= (tx_ir && !tx_q) ? 16'h1 : run_q + 16'h1;
         if (tx_ir && !tx_q) tx_period_seen <= run_q;
         hi_q <= tx_ir ? hi_q + 16'h1 : 16'h0;
         if (!tx_ir && tx_q) tx_high_seen <= hi_q;
      end
   end
endmodule
`default_nettype wire

/* tb/remote_ir_carrier_control_assertions.sv */
// Port checks on the remote infrared carrier control block
`timescale 1ns/100ps
`default_nettype none
module remote_ir_checker (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Register bus
   input  wire logic        s_axi_awvalid,
   input  wire logic        s_axi_awready,
   input  wire logic        s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [5:0]  s_axi_araddr,
   input  wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   // Line side
   input  wire logic        tx_enable,
   input  wire logic        tx_ir
);
   import remote_ir_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("late write answer");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
   a_write_block: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during answer");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("late read answer");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   a_byte_read: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_bad_index: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'h8
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read answered");
   a_tx_quiet: assert property (
      !tx_enable |=> !tx_ir) else $error("carrier while disabled");
endmodule
bind remote_ir_carrier_control remote_ir_checker u_remote_ir_checker (
   .clk_sys, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
   .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_enable, .tx_ir);
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the remote infrared carrier control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import remote_ir_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, tx_enable = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, tx_ir, rx_ir, rx_ok;
   logic [5:0]  awaddr = 6'h0, araddr = 6'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r;
   logic [15:0] rx_period = 16'h0, tx_per, tx_hi;
   logic [31:0] d, seed;
   int bad_count = 0, num_checks = 0, k;
   logic [7:0] v;
   always #2 clk_sys = ~clk_sys;
   remote_ir_carrier_control u_remote_ir_carrier_control (
      .clk_sys(clk_sys), .rstn(rstn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .tx_enable(tx_enable),
      .tx_ir(tx_ir), .rx_ir(rx_ir), .rx_carrier_ok(rx_ok));
   ir_front_end u_ir_front_end (.clk_sys(clk_sys), .rstn(rstn),
      .rx_period(rx_period), .rx_ir(rx_ir), .tx_ir(tx_ir),
      .tx_period_seen(tx_per), .tx_high_seen(tx_hi));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] b);
      logic aw_done, w_done, slow;
      aw_done = 1'b0;
      w_done = 1'b0;
      // A late bready keeps the answer waiting, so its hold is exercised
      slow = 1'($random(seed));
      @(posedge clk_sys);
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= !slow;
      awaddr <= {idx, 2'b00};
      wdata <= {$random(seed)} & 32'hffffff00 | {24'h0, b};
      while (!(aw_done && w_done)) begin
         @(posedge clk_sys);
         if (awready) aw_done = 1'b1;
         if (wready) w_done = 1'b1;
         if (aw_done) awvalid <= 1'b0;
         if (w_done) wvalid <= 1'b0;
      end
      do @(posedge clk_sys); while (!bvalid);
      if (slow) begin
         bready <= 1'b1;
         @(posedge clk_sys);
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] idx);
      logic slow;
      slow = 1'($random(seed));
      @(posedge clk_sys);
      arvalid <= 1'b1; rready <= !slow; araddr <= {idx, 2'b00};
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      if (slow) begin
         rready <= 1'b1;
         @(posedge clk_sys);
      end
      d = rdata; r = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [7:0] reset_of(input int i);
      return i == 0 ? 8'h29 : i == 1 ? 8'h69 : i == 3 ? 8'hf4 : 8'h00;
   endfunction
   function automatic int pw_cycles(input logic g, input logic [2:0] c);
      int ns[8] = '{0, 0, 6000, 7000, 9000, 10600, 0, 0};
      int hs[8] = '{0, 0, 700, 800, 900, 1000, 0, 0};
      return (g ? hs[c] : ns[c]) / 4;
   endfunction
   function automatic int carrier_khz(input logic g, input logic [4:0] s);
      if (!g) return int'(s) + 27;
      return s == 5'h03 ? 400 : s == 5'h08 ? 450 : 480;
   endfunction
   task automatic tx_case(input logic g, input logic [2:0] c,
                          input logic [4:0] s);
      int p;
      p = 250000 / carrier_khz(g, s);
      wr(IDX_IR_CONFIG, {4'h0, g, 3'h0});
      wr(IDX_TX_CONTROL, {c, s});
      tx_enable <= 1'b1;
      repeat (3 * p + 20) @(posedge clk_sys);
      chk(tx_per >= p && tx_per <= p + 1, 1);
      chk(tx_hi, pw_cycles(g, c));
      tx_enable <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(tx_ir, 0);
   endtask
   task automatic rx_case(input logic [7:0] cfg, input logic [7:0] mode,
                          input logic [7:0] rxc, input int p, input logic ok);
      wr(IDX_IR_CONFIG, cfg);
      wr(IDX_MODE_STATUS, mode);
      wr(IDX_RX_CONTROL, rxc);
      rx_period <= 16'(p);
      repeat (2 * p + 20) @(posedge clk_sys);
      chk(rx_ok, ok);
      rd(IDX_MODE_STATUS);
      chk(d[7], ok);
   endtask
   initial begin
      seed = 32'hc70f;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      for (k = 0; k < 8; k++) begin
         rd(4'(k));
         chk(d, reset_of(k));
      end
      $display("test reset values done");
      for (k = 0; k < 8; k++) begin
         v = 8'($random(seed));
         wr(4'(k), v);
         chk(r, RESP_OKAY);
         rd(4'(k));
         chk(d, {24'h0, v});
      end
      wr(4'h9, 8'h5a);
      chk(r, RESP_SLVERR);
      rd(4'h9);
      chk(r, RESP_SLVERR);
      // Status bits are read-only and idle here
      wr(IDX_MODE_STATUS, 8'hff);
      rd(IDX_MODE_STATUS);
      chk(d, 32'h01);
      $display("test register access done");
      tx_case(1'b0, 3'b011, 5'h09);
      tx_case(1'b1, 3'b101, 5'h0b);
      for (k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         tx_case(1'b1, 3'd2 + 3'(v[1:0]), v[2] ? 5'h03 : 5'h08);
      end
      // A reserved select must keep the line dark
      wr(IDX_TX_CONTROL, {3'b010, 5'h05});
      tx_enable <= 1'b1;
      v = 8'h0;
      repeat (800) @(posedge clk_sys) if (tx_ir) v = 8'h1;
      chk(v, 0);
      tx_enable <= 1'b0;
      $display("test transmit carrier done");
      rx_case(8'h00, 8'h00, 8'h29, 6944, 1'b1);
      rx_case(8'h00, 8'h00, 8'h21, 6944, 1'b0);
      rx_case(8'h20, 8'h00, 8'h23, 625, 1'b1);
      rx_case(8'h20, 8'h00, 8'h23, 833, 1'b0);
      rx_case(8'h20, 8'h00, 8'h23, 500, 1'b0);
      rx_case(8'h00, 8'h01, 8'h20, 500, 1'b1);
      rx_case(8'h00, 8'h01, 8'hc0, 357, 1'b1);
      rx_case(8'h00, 8'h01, 8'h20, 357, 1'b0);
      $display("test receive band done");
      give_verdict();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      bad_count++;
      give_verdict();
   end
endmodule
`default_nettype wire
